// File: rtl/flash_bus_pkg.sv
// Package of constants shared by the flash bus interface and both ends.
// Assumes a single 50 MHz clock domain on the host side of the bus.
package flash_bus_pkg;
    localparam int unsigned DATA_W        = 32;
    localparam int unsigned ADDR_W        = 20;
    localparam int unsigned BANK_HI       = 19;
    localparam int unsigned BANK_LO       = 17;
    // Top three address bits select the small bank when equal to this value.
    localparam logic [2:0]  SMALL_BANK    = 3'h7;
    localparam logic [7:0]  PROT_LOW_ADDR = 8'h02;
    localparam int unsigned PROT_PPB_BIT  = 0;
    localparam int unsigned PROT_DYB_BIT  = 1;
    // Boot-block write-protected sectors: two outermost 2K-dword sectors.
    localparam int unsigned WP_SECT_SHIFT = 11;
    localparam int unsigned SECT_W        = ADDR_W - WP_SECT_SHIFT;
    localparam logic [7:0]  CMD_READ_RST  = 8'hF0;
    localparam logic [7:0]  CMD_PROGRAM   = 8'hA0;
    localparam logic [7:0]  CMD_ERASE     = 8'h30;
    localparam logic [7:0]  CMD_SUSPEND   = 8'hB0;
    localparam logic [7:0]  CMD_RESUME    = 8'h30;
    localparam logic [7:0]  CMD_PROT_RD   = 8'h90;
    localparam int unsigned EMBED_CYCLES  = 16;
    localparam int unsigned CNT_W         = 8;
endpackage : flash_bus_pkg

// File: rtl/flash_bus_if.sv
// Interface carrying the flash bus pins between host and device ends.
// Assumes the testbench resolves the data bus from the two enables.
`timescale 1ns/100ps
`default_nettype none
interface flash_bus_if;
    logic                                 chip_select_n;
    logic                                 output_enable_n;
    logic                                 write_enable_n;
    logic                                 address_valid_n;
    logic                                 reset_n;
    logic                                 high_voltage_select_pin;
    logic                                 write_protect_n;
    logic [flash_bus_pkg::ADDR_W-1:0]     addr;
    logic [flash_bus_pkg::DATA_W-1:0]     dq_host;
    logic                                 dq_host_oe;
    logic [flash_bus_pkg::DATA_W-1:0]     dq_dev;
    logic                                 dq_dev_oe;

    modport host (
        output chip_select_n, output_enable_n, write_enable_n, address_valid_n,
        output reset_n, high_voltage_select_pin, write_protect_n, addr,
        output dq_host, dq_host_oe,
        input  dq_dev, dq_dev_oe
    );
    modport device (
        input  chip_select_n, output_enable_n, write_enable_n, address_valid_n,
        input  reset_n, high_voltage_select_pin, write_protect_n, addr,
        input  dq_host, dq_host_oe,
        output dq_dev, dq_dev_oe
    );
endinterface : flash_bus_if
`default_nettype wire

// File: rtl/flash_bus_device.sv
// Device end: decodes bus control levels into read, write, burst, status
// and simultaneous-operation behaviour of a two-bank burst flash.
// Assumes bus pins come from another domain and are double-synchronised.
`timescale 1ns/100ps
`default_nettype none
module flash_bus_device #(
    parameter int unsigned DEPTH    = 64,
    parameter bit          TOP_BOOT = 1'b1
) (
    input  wire logic                              clk_in,
    input  wire logic                              rst_n_in,
    input  wire logic                              clk_en_in,
    flash_bus_if.device                            bus,
    input  wire logic [flash_bus_pkg::SECT_W-1:0]  prot_sector_in,
    input  wire logic                              prot_ppb_in,
    input  wire logic                              prot_dyb_in,
    output logic                                   busy_out,
    output logic                                   refused_out
);
    typedef enum logic [2:0] {
        ST_ARRAY = 3'b001,
        ST_PROT  = 3'b010,
        ST_CMD   = 3'b100
    } mode_e;

    ////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers on every bus input except dq_host_oe; first stage read only here.
    localparam int unsigned SW = 7 + flash_bus_pkg::ADDR_W + flash_bus_pkg::DATA_W;
    logic [SW-1:0] sync_a;
    logic [SW-1:0] sync_b;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync_a <= {SW{1'b1}};
            sync_b <= {SW{1'b1}};
        end else if (clk_en_in) begin
            sync_a <= {bus.chip_select_n, bus.output_enable_n, bus.write_enable_n,
                       bus.address_valid_n, bus.reset_n, bus.high_voltage_select_pin,
                       bus.write_protect_n, bus.addr, bus.dq_host};
            sync_b <= sync_a;
        end
    end
    logic                               cs_n, oe_n, we_n, adv_n, dev_rst_n, hv, wp_n;
    logic [flash_bus_pkg::ADDR_W-1:0]   a;
    logic [flash_bus_pkg::DATA_W-1:0]   din;
    assign {cs_n, oe_n, we_n, adv_n, dev_rst_n, hv, wp_n, a, din} = sync_b;

    // Decoded bus operations.
    logic read_op, write_op, load_op, adv_op, we_q, write_strobe;
    assign read_op  = !cs_n && !oe_n && we_n;
    assign write_op = !cs_n && oe_n && !we_n;
    assign load_op  = !cs_n && we_n && !adv_n;
    assign adv_op   = !cs_n && !oe_n && we_n && adv_n;
    // A command is taken in the cycle after its write level ends. The host may
    // raise chip select together with write enable, so no select test is made here.
    assign write_strobe = !we_q && !write_op;

    ////////////////////////////////////////////////////////////////////////
    // Command latches: not mapped at any address; steer the mode, the engine and program writes.
    logic [flash_bus_pkg::ADDR_W-1:0] cmd_addr;
    logic [flash_bus_pkg::DATA_W-1:0] cmd_data;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            we_q     <= 1'b1;
            cmd_addr <= '0;
            cmd_data <= '0;
        end else if (clk_en_in) begin
            we_q <= !write_op;
            if (!dev_rst_n) begin
                cmd_addr <= '0;
                cmd_data <= '0;
            end else if (write_op) begin
                // Address may come from an earlier clocked load when synchronous.
                cmd_addr <= adv_n ? a : cmd_addr;
                cmd_data <= din;
            end else if (load_op) begin
                cmd_addr <= a;
            end
        end
    end
    logic       cmd_take;
    logic [7:0] cmd_byte;
    assign cmd_take = write_strobe;
    assign cmd_byte = cmd_data[7:0];

    ////////////////////////////////////////////////////////////////////////
    // Mode machine: read-array after reset, changes only on a new command.
    mode_e mode;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode <= ST_ARRAY;
        end else if (clk_en_in) begin
            if (!dev_rst_n) begin
                mode <= ST_ARRAY;
            end else if (cmd_take) begin
                if (cmd_byte == flash_bus_pkg::CMD_READ_RST) begin
                    mode <= ST_ARRAY;
                end else if (cmd_byte == flash_bus_pkg::CMD_PROT_RD) begin
                    mode <= ST_PROT;
                end else begin
                    mode <= ST_CMD;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Embedded program/erase engine with bank tracking and suspend.
    logic                         busy, busy_small, suspended;
    logic [flash_bus_pkg::CNT_W-1:0] op_cnt;
    logic cmd_small, wp_hit, start_ok;
    assign cmd_small = cmd_addr[flash_bus_pkg::BANK_HI:flash_bus_pkg::BANK_LO]
                       == flash_bus_pkg::SMALL_BANK;
    // Two outermost sectors at the boot end of the map.
    assign wp_hit = !wp_n && (TOP_BOOT
        ? (&cmd_addr[flash_bus_pkg::ADDR_W-1:flash_bus_pkg::WP_SECT_SHIFT+1])
        : (~|cmd_addr[flash_bus_pkg::ADDR_W-1:flash_bus_pkg::WP_SECT_SHIFT+1]));
    assign start_ok = (cmd_byte == flash_bus_pkg::CMD_PROGRAM ||
                       cmd_byte == flash_bus_pkg::CMD_ERASE) && !busy && !wp_hit;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            busy       <= 1'b0;
            busy_small <= 1'b0;
            suspended  <= 1'b0;
            op_cnt     <= '0;
        end else if (clk_en_in) begin
            if (!dev_rst_n) begin
                busy      <= 1'b0;
                suspended <= 1'b0;
                op_cnt    <= '0;
            end else if (cmd_take && busy && cmd_byte == flash_bus_pkg::CMD_SUSPEND) begin
                suspended <= 1'b1;
            end else if (cmd_take && busy && suspended && cmd_byte == flash_bus_pkg::CMD_RESUME) begin
                suspended <= 1'b0;
            end else if (cmd_take && start_ok) begin
                busy       <= 1'b1;
                busy_small <= cmd_small;
                op_cnt     <= flash_bus_pkg::CNT_W'(flash_bus_pkg::EMBED_CYCLES);
            end else if (busy && !suspended) begin
                op_cnt <= op_cnt - 1'b1;
                busy   <= op_cnt != 1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path: array, burst and protection status; both banks share one array.
    logic [flash_bus_pkg::DATA_W-1:0] mem [DEPTH];
    logic [flash_bus_pkg::ADDR_W-1:0] burst_addr;
    logic                             burst_on, addr_small, bank_blocked, prot_sel;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            burst_on   <= 1'b0;
            burst_addr <= '0;
        end else if (clk_en_in) begin
            if (!dev_rst_n || cs_n) begin
                burst_on <= 1'b0;
            end else if (load_op) begin
                burst_on   <= 1'b1;
                burst_addr <= a;
            end else if (adv_op && burst_on) begin
                burst_addr <= burst_addr + 1'b1;
            end
        end
    end
    // Simple pattern memory stands in for the array; program writes it.
    always_ff @(posedge clk_in) begin
        if (clk_en_in && cmd_take && start_ok && cmd_byte == flash_bus_pkg::CMD_PROGRAM) begin
            mem[cmd_addr[$clog2(DEPTH)-1:0]] <= cmd_data;
        end
    end
    logic [flash_bus_pkg::ADDR_W-1:0] rd_addr;
    assign rd_addr      = burst_on ? burst_addr : a;
    assign addr_small   = rd_addr[flash_bus_pkg::BANK_HI:flash_bus_pkg::BANK_LO]
                          == flash_bus_pkg::SMALL_BANK;
    // The bank being written may not be read; large-bank writes block all.
    assign bank_blocked = busy && !suspended && (!busy_small || addr_small);
    assign prot_sel     = hv && a[7:0] == flash_bus_pkg::PROT_LOW_ADDR &&
                          !busy &&
                          a[flash_bus_pkg::ADDR_W-1:flash_bus_pkg::WP_SECT_SHIFT] == prot_sector_in;
    logic [flash_bus_pkg::DATA_W-1:0] next_dq;
    always_comb begin
        next_dq = mem[rd_addr[$clog2(DEPTH)-1:0]];
        if (prot_sel || (mode == ST_PROT && !busy)) begin
            next_dq = '0;
            next_dq[flash_bus_pkg::PROT_PPB_BIT] = prot_ppb_in;
            next_dq[flash_bus_pkg::PROT_DYB_BIT] = prot_dyb_in;
        end
    end
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bus.dq_dev    <= '0;
            bus.dq_dev_oe <= 1'b0;
            busy_out      <= 1'b0;
            refused_out   <= 1'b0;
        end else if (clk_en_in) begin
            busy_out    <= busy;
            refused_out <= read_op && bank_blocked;
            // Float on reset, standby and output disable.
            bus.dq_dev_oe <= dev_rst_n && read_op && !bank_blocked;
            bus.dq_dev    <= next_dq;
        end
    end
endmodule : flash_bus_device
`default_nettype wire

// File: rtl/flash_bus_host.sv
// Host end: turns one-cycle user requests into flash bus control levels.
// Assumes a single clock; device data arrives through two flip-flops.
`timescale 1ns/100ps
`default_nettype none
module flash_bus_host (
    input  wire logic                              clk_in,
    input  wire logic                              rst_n_in,
    input  wire logic                              clk_en_in,
    flash_bus_if.host                              bus,
    input  wire logic                              req_in,
    input  wire logic [1:0]                        kind_in,
    input  wire logic [flash_bus_pkg::ADDR_W-1:0]  addr_in,
    input  wire logic [flash_bus_pkg::DATA_W-1:0]  wdata_in,
    input  wire logic                              hv_in,
    input  wire logic                              wp_n_in,
    input  wire logic                              dev_rst_n_in,
    output logic                                   done_out,
    output logic [flash_bus_pkg::DATA_W-1:0]       rdata_out
);
    // Kinds: 0 read, 1 write, 2 burst load, 3 burst advance.
    typedef enum logic [3:0] {
        H_IDLE  = 4'b0001,
        H_DRIVE = 4'b0010,
        H_WAIT  = 4'b0100,
        H_END   = 4'b1000
    } hstate_e;
    // Two input flops, the device output flop and two return flops: read data
    // reaches rd_b only five edges after the request is taken.
    localparam logic [2:0] WAIT_CYC = 3'h5;
    hstate_e st;
    logic [1:0] kind;
    logic [2:0] cnt;
    logic [flash_bus_pkg::DATA_W-1:0] rd_a, rd_b;

    ////////////////////////////////////////////////////////////////////////
    // Device data passes two flip-flops before use.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_a <= '0;
            rd_b <= '0;
        end else if (clk_en_in) begin
            rd_a <= bus.dq_dev;
            rd_b <= rd_a;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer holds each access for enough cycles to pass synchronisers.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st                          <= H_IDLE;
            kind                        <= 2'h0;
            cnt                         <= 3'h0;
            done_out                    <= 1'b0;
            rdata_out                   <= '0;
            bus.chip_select_n           <= 1'b1;
            bus.output_enable_n         <= 1'b1;
            bus.write_enable_n          <= 1'b1;
            bus.address_valid_n         <= 1'b1;
            bus.reset_n                 <= 1'b0;
            bus.high_voltage_select_pin <= 1'b0;
            bus.write_protect_n         <= 1'b1;
            bus.addr                    <= '0;
            bus.dq_host                 <= '0;
            bus.dq_host_oe              <= 1'b0;
        end else if (clk_en_in) begin
            done_out                    <= 1'b0;
            bus.reset_n                 <= dev_rst_n_in;
            bus.write_protect_n         <= wp_n_in;
            unique case (st)
                H_IDLE: begin
                    if (req_in) begin
                        kind                        <= kind_in;
                        bus.addr                    <= addr_in;
                        bus.high_voltage_select_pin <= hv_in;
                        bus.chip_select_n           <= 1'b0;
                        bus.write_enable_n          <= kind_in != 2'h1;
                        bus.output_enable_n         <= kind_in == 2'h1 || kind_in == 2'h2;
                        bus.address_valid_n         <= kind_in != 2'h2;
                        bus.dq_host                 <= wdata_in;
                        bus.dq_host_oe              <= kind_in == 2'h1;
                        cnt                         <= WAIT_CYC;
                        st                          <= H_WAIT;
                    end
                end
                H_WAIT: begin
                    cnt <= cnt - 3'h1;
                    if (cnt == 3'h1) begin
                        st <= H_DRIVE;
                    end
                end
                H_DRIVE: begin
                    rdata_out           <= rd_b;
                    bus.write_enable_n  <= 1'b1;
                    bus.address_valid_n <= 1'b1;
                    // Burst stays selected so the device keeps its address.
                    bus.chip_select_n   <= kind == 2'h2 || kind == 2'h3 ? 1'b0 : 1'b1;
                    bus.output_enable_n <= 1'b1;
                    bus.dq_host_oe      <= 1'b0;
                    st                  <= H_END;
                end
                H_END: begin
                    done_out <= 1'b1;
                    st       <= H_IDLE;
                end
                default: begin
                    st <= H_IDLE;
                end
            endcase
        end
    end
endmodule : flash_bus_host
`default_nettype wire

// File: test/flash_bus_chk.sv
// Checker for the flash bus that joins the host and device ends.
// Assumes one clock domain and instantiation beside the interface.
`timescale 1ns/100ps
`default_nettype none
module flash_bus_chk (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic chip_select_n,
    input wire logic output_enable_n,
    input wire logic write_enable_n,
    input wire logic address_valid_n,
    input wire logic reset_n,
    input wire logic dq_host_oe,
    input wire logic dq_dev_oe
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    ////////////////////////////////////////////////////////////////////////////
    // Levels held for four samples, which covers the two-flop input delay.
    sequence deselected;
        chip_select_n [*4];
    endsequence
    sequence out_disabled;
        (output_enable_n && write_enable_n) [*4];
    endsequence
    sequence held_reset;
        !reset_n [*4];
    endsequence
    sequence dev_drive_start;
        $rose(dq_dev_oe);
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    // The device may only start driving after a read was presented.
    chk_drive_needs_read: assert property (dev_drive_start |-> $past(!chip_select_n && !output_enable_n, 2))
        else $error("device drove data without a read request");
    chk_host_quiet_read: assert property (!output_enable_n |-> !dq_host_oe)
        else $error("host drove data while output enable was low");
    chk_read_we_high: assert property (!output_enable_n |-> write_enable_n)
        else $error("write enable low during a read");
    chk_load_selected: assert property (!address_valid_n |-> !chip_select_n && write_enable_n)
        else $error("address strobe without chip select and write high");
    chk_reset_floats: assert property (held_reset |-> !dq_dev_oe)
        else $error("data driven while reset held low");
    chk_standby_floats: assert property (deselected |-> !dq_dev_oe)
        else $error("data driven while deselected");
    chk_outdis_floats: assert property (out_disabled |-> !dq_dev_oe)
        else $error("data driven with output and write enable high");
    chk_write_levels: assert property ($fell(write_enable_n) |-> !chip_select_n && output_enable_n)
        else $error("write started without chip select or with output enable low");
    // A write strobe that never ends would stop the command from ever latching.
    chk_write_ends: assert property (!write_enable_n |-> ##[1:8] write_enable_n)
        else $error("write enable held low too long");
endmodule : flash_bus_chk
`default_nettype wire

// File: test/flash_bus_operation_decoder_tb.sv
// Testbench for the host and device ends of the flash bus decoder.
// Assumes the package, interface, both ends and the checker compile first.
`timescale 1ns/100ps
`default_nettype none
module flash_bus_operation_decoder_tb;
    typedef struct packed {
        logic [8:0]  sector;
        logic        persistent_protect_bit;
        logic        dynamic_protect_bit;
        logic [31:0] exp;
    } row_s;
    logic        clk_in;
    logic        rst_n_in       = 1'b0;
    logic        req_in         = 1'b0;
    logic [1:0]  kind_in        = 2'h0;
    logic [19:0] addr_in        = 20'h0_0000;
    logic [31:0] wdata_in       = 32'h0000_0000;
    logic        hv_in          = 1'b0;
    logic        wp_n_in        = 1'b1;
    logic        dev_rst_n_in   = 1'b1;
    logic [8:0]  prot_sector_in = 9'h000;
    logic        prot_ppb_in    = 1'b0;
    logic        prot_dyb_in    = 1'b0;
    logic        saw_refused    = 1'b0;
    logic        done_out;
    logic [31:0] rdata_out;
    logic        busy_out;
    logic        refused_out;
    int          err_count      = 0;
    int          checks_done    = 0;
    row_s        rows [4];
    flash_bus_if flash_bus_if_inst ();
    flash_bus_host flash_bus_host_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .clk_en_in(1'b1),
        .bus(flash_bus_if_inst.host), .req_in(req_in), .kind_in(kind_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .hv_in(hv_in), .wp_n_in(wp_n_in), .dev_rst_n_in(dev_rst_n_in),
        .done_out(done_out), .rdata_out(rdata_out));
    flash_bus_device flash_bus_device_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .clk_en_in(1'b1),
        .bus(flash_bus_if_inst.device), .prot_sector_in(prot_sector_in), .prot_ppb_in(prot_ppb_in),
        .prot_dyb_in(prot_dyb_in), .busy_out(busy_out), .refused_out(refused_out));
    flash_bus_chk flash_bus_chk_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .chip_select_n(flash_bus_if_inst.chip_select_n), .output_enable_n(flash_bus_if_inst.output_enable_n),
        .write_enable_n(flash_bus_if_inst.write_enable_n), .address_valid_n(flash_bus_if_inst.address_valid_n),
        .reset_n(flash_bus_if_inst.reset_n), .dq_host_oe(flash_bus_if_inst.dq_host_oe),
        .dq_dev_oe(flash_bus_if_inst.dq_dev_oe));
    ////////////////////////////////////////////////////////////////////////////
    // Free-running 50 MHz clock.
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    // The refusal flag lasts only while the read is seen, so it is caught here for the task.
    always @(posedge clk_in) begin
        if (refused_out === 1'b1) begin
            saw_refused <= 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Shared comparison, closing report and bus request tasks.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask : check
    task automatic test_done();
        $display("checks=%0d errors=%0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : tick
    // A bounded wait for done, so a hung bus ends the run instead of stalling it.
    task automatic do_op(input logic [1:0] kind, input logic [19:0] addr, input logic [31:0] wdata);
        int n;
        tick(1);
        saw_refused = 1'b0;
        req_in = 1'b1;
        kind_in = kind;
        addr_in = addr;
        wdata_in = wdata;
        tick(1);
        req_in = 1'b0;
        for (n = 0; n < 20 && done_out !== 1'b1; n++) begin
            tick(1);
        end
        if (done_out !== 1'b1) begin
            check({31'h0, done_out}, 32'h1);
            test_done();
        end
    endtask : do_op
    // The engine starts a few cycles after the write strobe rises.
    task automatic cmd(input logic [19:0] addr, input logic [7:0] code);
        do_op(2'h1, addr, {24'h00_0000, code});
        tick(3);
    endtask : cmd
    task automatic wait_idle();
        int n;
        for (n = 0; n < 60 && busy_out !== 1'b0; n++) begin
            tick(1);
        end
        check({31'h0, busy_out}, 32'h0);
        if (busy_out !== 1'b0) begin
            test_done();
        end
    endtask : wait_idle
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence: status rows first, then the awkward cases by hand.
    initial begin
        rows[0] = '{9'h000, 1'b1, 1'b0, 32'h0000_0001};
        rows[1] = '{9'h1FF, 1'b0, 1'b1, 32'h0000_0002};
        rows[2] = '{9'h0A5, 1'b1, 1'b1, 32'h0000_0003};
        rows[3] = '{9'h040, 1'b0, 1'b0, 32'h0000_0000};
        repeat (16) @(posedge clk_in);
        #1 rst_n_in = 1'b1;
        tick(1);
        check({30'h0, busy_out, flash_bus_if_inst.dq_dev_oe}, 32'h0);
        hv_in = 1'b1;
        foreach (rows[i]) begin
            prot_sector_in = rows[i].sector;
            prot_ppb_in = rows[i].persistent_protect_bit;
            prot_dyb_in = rows[i].dynamic_protect_bit;
            do_op(2'h0, {rows[i].sector, 3'h0, 8'h02}, 32'h0000_0000);
            check(rdata_out, rows[i].exp);
        end
        hv_in = 1'b0;
        $display("test status rows done");
        do_op(2'h2, 20'h0_0100, 32'h0000_0000);
        do_op(2'h3, 20'h0_0100, 32'h0000_0000);
        do_op(2'h3, 20'h0_0100, 32'h0000_0000);
        check({31'h0, saw_refused}, 32'h0);
        $display("test burst done");
        cmd(20'hE_0002, flash_bus_pkg::CMD_PROGRAM);
        check({31'h0, busy_out}, 32'h1);
        // Status inputs are set so that a status word would differ from the array word.
        hv_in = 1'b1;
        prot_sector_in = rows[0].sector;
        prot_ppb_in = rows[0].persistent_protect_bit;
        do_op(2'h0, 20'h0_0002, 32'h0000_0000);
        check({31'h0, saw_refused}, 32'h0);
        check(rdata_out, {24'h00_0000, flash_bus_pkg::CMD_PROGRAM});
        hv_in = 1'b0;
        do_op(2'h0, 20'hE_0010, 32'h0000_0000);
        check({31'h0, saw_refused}, 32'h1);
        wait_idle();
        $display("test small bank write done");
        cmd(20'hE_0000, flash_bus_pkg::CMD_PROGRAM);
        cmd(20'hE_0000, flash_bus_pkg::CMD_SUSPEND);
        // A suspended program still counts as busy, but its bank is free for reads.
        check({31'h0, busy_out}, 32'h1);
        do_op(2'h0, 20'hE_0010, 32'h0000_0000);
        check({31'h0, saw_refused}, 32'h0);
        cmd(20'hE_0000, flash_bus_pkg::CMD_RESUME);
        check({31'h0, busy_out}, 32'h1);
        do_op(2'h2, 20'h0_2000, 32'h0000_0000);
        do_op(2'h3, 20'h0_2000, 32'h0000_0000);
        check({31'h0, saw_refused}, 32'h0);
        wait_idle();
        $display("test suspend done");
        cmd(20'h0_4000, flash_bus_pkg::CMD_ERASE);
        do_op(2'h0, 20'hE_0020, 32'h0000_0000);
        check({31'h0, saw_refused}, 32'h1);
        wait_idle();
        $display("test large bank write done");
        wp_n_in = 1'b0;
        cmd(20'hF_F000, flash_bus_pkg::CMD_PROGRAM);
        check({31'h0, busy_out}, 32'h0);
        cmd(20'hE_0000, flash_bus_pkg::CMD_PROGRAM);
        check({31'h0, busy_out}, 32'h1);
        wait_idle();
        wp_n_in = 1'b1;
        $display("test write protect done");
        cmd(20'h0_4000, flash_bus_pkg::CMD_ERASE);
        dev_rst_n_in = 1'b0;
        tick(8);
        check({30'h0, busy_out, flash_bus_if_inst.dq_dev_oe}, 32'h0);
        dev_rst_n_in = 1'b1;
        tick(4);
        hv_in = 1'b1;
        prot_sector_in = rows[2].sector;
        prot_ppb_in = rows[2].persistent_protect_bit;
        prot_dyb_in = rows[2].dynamic_protect_bit;
        do_op(2'h0, {rows[2].sector, 3'h0, 8'h02}, 32'h0000_0000);
        check(rdata_out, rows[2].exp);
        $display("test bus reset done");
        hv_in = 1'b0;
        cmd(20'h0_0000, flash_bus_pkg::CMD_PROT_RD);
        do_op(2'h0, 20'h0_0000, 32'h0000_0000);
        check(rdata_out, rows[2].exp);
        cmd(20'h0_0000, flash_bus_pkg::CMD_READ_RST);
        do_op(2'h0, 20'h0_0000, 32'h0000_0000);
        check(rdata_out, {24'h00_0000, flash_bus_pkg::CMD_PROGRAM});
        $display("test command modes done");
        test_done();
    end
endmodule : flash_bus_operation_decoder_tb
`default_nettype wire
